/* hdl/phy_monitor_lowpower_link_cfg.sv */
/*
  register group for sensor monitor sequencer, link teardown options,
  low power signalling codes and the training max-wait timer.
  assumes a word-wide management register port with one-cycle strobes, adc
  samples and code groups synchronous to i_clk.
*/
// Function
// - hold-in-reset bit forces sequencer reset immediately
// - repeat bit selects single or periodic runs
// - start bit launches sequencer, clears itself
// - forced start runs without established link
// - discard 2 or 4 samples first
// - average 2 or 4 samples per result
// - divider field sets adc clock rate
// - readback select picks adc output shown
// - fifo held reset during break-link timer
// - slave sends SEND_S exactly 32 times
// - transmit wake code from its field
// - transmit sleep code from its field
// - receive wake code taken from field
// - receive sleep code taken from field
// - wake flagged after threshold consecutive groups
// - sleep flagged after threshold consecutive groups
// - max-wait load times sixteen microseconds
`timescale 1ns/1ps
module phy_monitor_lowpower_link_cfg (
  // clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  // management register port
  input  wire phy_cfg_pkg::reg_req_t i_req,
  output logic      [15:0]           o_rdata,
  output logic                       o_rvalid,
  // monitor adc and debug select
  input  wire logic                  i_link_up,
  input  wire logic                  i_adc_valid,
  input  wire logic [15:0]           i_adc_data,
  input  wire logic [2:0]            i_rd_select,
  output logic                       o_adc_clk_en,
  output logic                       o_mon_busy,
  // training and teardown
  input  wire logic                  i_break_timer_run,
  input  wire logic                  i_slave_role,
  input  wire logic                  i_send_s_seen,
  input  wire logic                  i_send_s_slot,
  input  wire logic                  i_training_start,
  output logic                       o_adc_fifo_rst,
  output logic                       o_send_s_fixed,
  output logic                       o_send_s_tx,
  output logic                       o_maxwait_done,
  // low power signalling
  input  wire logic                  i_lp_tx_wake_req,
  input  wire logic                  i_lp_tx_sleep_req,
  input  wire logic                  i_rx_cg_valid,
  input  wire logic [2:0]            i_rx_cg,
  output logic      [2:0]            o_tx_code,
  output logic                       o_tx_code_valid,
  output logic                       o_lp_wake_rcvd,
  output logic                       o_lp_sleep_rcvd
);
  import phy_cfg_pkg::*;

  typedef enum logic [2:0] {MS_IDLE, MS_DISCARD, MS_AVERAGE, MS_STORE, MS_WAIT} mon_fsm_t;

  typedef struct packed {
    logic [15:0] mon_ctrl;
    logic [15:0] teardown;
    logic [15:0] lp_codes;
    logic [15:0] lp_thresh;
    logic [15:0] maxwait;
    logic [15:0] rdata;
    logic        rvalid;
    logic [2:0]  div_cnt;
    mon_fsm_t    fsm;
    logic [2:0]  smp_cnt;
    logic [17:0] acc;
    logic [15:0] result;
    logic [HIST_AW-1:0] wptr;
    logic [7:0]  gap;
    logic [5:0]  send_cnt;
    logic        send_active;
    logic        send_done;
    logic [4:0]  us_cnt;
    logic [19:0] mw_cnt;
    logic        mw_run;
    logic        mw_done;
    lp_tx_t      tx;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic [15:0] hist_rdata;
  logic        hist_we;
  logic [15:0] hist_wdata;

  // write merge keeps reserved bits at zero
  function automatic logic [15:0] merge(input logic [15:0] wdata, input logic [15:0] mask);
    merge = wdata & mask;
  endfunction

  // adc tick terminal count for the divider code
  function automatic logic [2:0] div_top(input logic [1:0] code);
    if (code == 2'b00) begin
      div_top = 3'h1;
    end else if (code == 2'b01) begin
      div_top = 3'h3;
    end else begin
      div_top = 3'h7;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // history storage
  mon_history_mem u_hist (
    .i_clk   (i_clk),
    .i_we    (hist_we),
    .i_waddr (s_q.wptr),
    .i_wdata (hist_wdata),
    .i_raddr (s_q.wptr - {{(HIST_AW-1){1'b0}}, 1'b1}),
    .o_rdata (hist_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // low power receive detectors
  lp_code_detect u_wake_det (
    .i_clk    (i_clk),
    .i_rst    (i_rst),
    .i_valid  (i_rx_cg_valid),
    .i_code   (i_rx_cg),
    .i_expect (s_q.lp_codes[RX_WAKE_LSB +: 3]),
    .i_thresh (s_q.lp_thresh[WAKE_TH_LSB +: 7]),
    .o_detect (o_lp_wake_rcvd)
  );

  lp_code_detect u_sleep_det (
    .i_clk    (i_clk),
    .i_rst    (i_rst),
    .i_valid  (i_rx_cg_valid),
    .i_code   (i_rx_cg),
    .i_expect (s_q.lp_codes[RX_SLEEP_LSB +: 3]),
    .i_thresh (s_q.lp_thresh[SLEEP_TH_LSB +: 7]),
    .o_detect (o_lp_sleep_rcvd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state
  logic       adc_tick;
  logic       mon_rst;
  logic       run_ok;
  logic [2:0] disc_n;
  logic [2:0] avg_n;

  always_comb begin
    s_d      = s_q;
    hist_we  = 1'b0;
    // new average, stored in the same cycle it is latched
    hist_wdata = s_q.mon_ctrl[MON_AVG_BIT] ? s_q.acc[17:2] : s_q.acc[16:1];
    adc_tick = 1'b0;
    mon_rst  = s_q.mon_ctrl[MON_RESET_BIT];
    run_ok   = i_link_up | s_q.mon_ctrl[MON_FORCE_BIT];
    disc_n   = s_q.mon_ctrl[MON_DISC_BIT] ? DISC_MANY : DISC_FEW;
    avg_n    = s_q.mon_ctrl[MON_AVG_BIT] ? AVG_MANY : AVG_FEW;

    // register access
    s_d.rvalid = i_req.rd;
    if (i_req.rd) begin
      if (i_req.addr == OFF_MON_CTRL) begin
        s_d.rdata = s_q.mon_ctrl;
      end else if (i_req.addr == OFF_MON_RDBK) begin
        s_d.rdata = (i_rd_select == 3'h0) ? s_q.result : hist_rdata;
      end else if (i_req.addr == OFF_TEARDOWN) begin
        s_d.rdata = s_q.teardown;
      end else if (i_req.addr == OFF_LP_CODES) begin
        s_d.rdata = s_q.lp_codes;
      end else if (i_req.addr == OFF_LP_THRESH) begin
        s_d.rdata = s_q.lp_thresh;
      end else if (i_req.addr == OFF_MAXWAIT) begin
        s_d.rdata = s_q.maxwait;
      end else begin
        s_d.rdata = 16'h0000;
      end
    end
    if (i_req.wr) begin
      if (i_req.addr == OFF_MON_CTRL) begin
        s_d.mon_ctrl = merge(i_req.wdata, MSK_MON_CTRL);
      end else if (i_req.addr == OFF_TEARDOWN) begin
        s_d.teardown = merge(i_req.wdata, MSK_TEARDOWN);
      end else if (i_req.addr == OFF_LP_CODES) begin
        s_d.lp_codes = merge(i_req.wdata, MSK_LP_CODES);
      end else if (i_req.addr == OFF_LP_THRESH) begin
        s_d.lp_thresh = merge(i_req.wdata, MSK_LP_THRESH);
      end else if (i_req.addr == OFF_MAXWAIT) begin
        s_d.maxwait = merge(i_req.wdata, MSK_MAXWAIT);
      end
    end

    // adc clock enable divider
    if (s_q.div_cnt >= div_top(s_q.mon_ctrl[MON_DIV_LSB +: 2])) begin
      s_d.div_cnt = 3'h0;
      adc_tick    = 1'b1;
    end else begin
      s_d.div_cnt = s_q.div_cnt + 3'h1;
    end

    // history clear, self clearing strobe
    if (s_q.mon_ctrl[MON_HCLR_BIT]) begin
      s_d.wptr   = '0;
      s_d.result = 16'h0000;
      s_d.mon_ctrl[MON_HCLR_BIT] = 1'b0;
    end

    // monitor sequencer
    case (s_q.fsm)
      MS_IDLE: begin
        if (s_q.mon_ctrl[MON_START_BIT] && run_ok) begin
          s_d.fsm     = MS_DISCARD;
          s_d.smp_cnt = 3'h0;
          s_d.acc     = '0;
          s_d.mon_ctrl[MON_START_BIT] = 1'b0;
        end
      end
      MS_DISCARD: begin
        if (adc_tick && i_adc_valid) begin
          if (s_q.smp_cnt + 3'h1 >= disc_n) begin
            s_d.fsm     = MS_AVERAGE;
            s_d.smp_cnt = 3'h0;
          end else begin
            s_d.smp_cnt = s_q.smp_cnt + 3'h1;
          end
        end
      end
      MS_AVERAGE: begin
        if (adc_tick && i_adc_valid) begin
          s_d.acc = s_q.acc + {2'b00, i_adc_data};
          if (s_q.smp_cnt + 3'h1 >= avg_n) begin
            s_d.fsm = MS_STORE;
          end else begin
            s_d.smp_cnt = s_q.smp_cnt + 3'h1;
          end
        end
      end
      MS_STORE: begin
        s_d.result = hist_wdata;
        hist_we    = 1'b1;
        s_d.wptr   = s_q.wptr + {{(HIST_AW-1){1'b0}}, 1'b1};
        s_d.gap    = PERIOD_GAP;
        s_d.fsm    = s_q.mon_ctrl[MON_PERIODIC] ? MS_WAIT : MS_IDLE;
      end
      MS_WAIT: begin
        if (!s_q.mon_ctrl[MON_PERIODIC]) begin
          s_d.fsm = MS_IDLE;
        end else if (adc_tick) begin
          if (s_q.gap == 8'h00) begin
            s_d.fsm     = MS_DISCARD;
            s_d.smp_cnt = 3'h0;
            s_d.acc     = '0;
          end else begin
            s_d.gap = s_q.gap - 8'h01;
          end
        end
      end
      default: s_d.fsm = MS_IDLE;
    endcase

    // hold-in-reset overrides the sequencer at once
    if (mon_rst) begin
      s_d.fsm     = MS_IDLE;
      s_d.smp_cnt = 3'h0;
      s_d.acc     = '0;
      s_d.gap     = 8'h00;
      if (!(i_req.wr && i_req.addr == OFF_MON_CTRL)) begin
        s_d.mon_ctrl[MON_START_BIT] = 1'b0;
      end
    end

    // slave fixed SEND_S repeat count
    if (!(s_q.teardown[TD_SEND32_BIT] && i_slave_role)) begin
      s_d.send_active = 1'b0;
      s_d.send_done   = 1'b0;
      s_d.send_cnt    = 6'h00;
    end else if (!s_q.send_active && !s_q.send_done && i_send_s_seen) begin
      s_d.send_active = 1'b1;
      s_d.send_cnt    = 6'h00;
    end else if (s_q.send_active && i_send_s_slot) begin
      if (s_q.send_cnt + 6'h01 >= SEND_S_COUNT) begin
        s_d.send_active = 1'b0;
        s_d.send_done   = 1'b1;
      end
      s_d.send_cnt = s_q.send_cnt + 6'h01;
    end

    // max-wait timer in 16 us units
    if (i_training_start) begin
      s_d.mw_run  = 1'b1;
      s_d.mw_done = 1'b0;
      s_d.us_cnt  = 5'h00;
      s_d.mw_cnt  = {s_q.maxwait, 4'h0};
    end else if (s_q.mw_run) begin
      if (s_q.us_cnt == 5'(CYC_PER_US - 1)) begin
        s_d.us_cnt = 5'h00;
        if (s_q.mw_cnt <= 20'h00001) begin
          s_d.mw_run  = 1'b0;
          s_d.mw_done = 1'b1;
          s_d.mw_cnt  = 20'h00000;
        end else begin
          s_d.mw_cnt = s_q.mw_cnt - 20'h00001;
        end
      end else begin
        s_d.us_cnt = s_q.us_cnt + 5'h01;
      end
    end

    // transmit code register
    s_d.tx.tx_wake  = s_q.lp_codes[TX_WAKE_LSB +: 3];
    s_d.tx.tx_sleep = s_q.lp_codes[TX_SLEEP_LSB +: 3];
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_q           <= '0;
      s_q.mon_ctrl  <= RST_MON_CTRL;
      s_q.teardown  <= RST_TEARDOWN;
      s_q.lp_codes  <= RST_LP_CODES;
      s_q.lp_thresh <= RST_LP_THRESH;
      s_q.maxwait   <= RST_MAXWAIT;
      s_q.fsm       <= MS_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign o_rdata         = s_q.rdata;
  assign o_rvalid        = s_q.rvalid;
  assign o_adc_clk_en    = adc_tick & ~s_q.mon_ctrl[MON_RESET_BIT];
  assign o_mon_busy      = (s_q.fsm != MS_IDLE);
  assign o_adc_fifo_rst  = s_q.teardown[TD_FIFO_BIT] & i_break_timer_run;
  assign o_send_s_fixed  = s_q.teardown[TD_SEND32_BIT];
  assign o_send_s_tx     = s_q.send_active;
  assign o_maxwait_done  = s_q.mw_done;
  assign o_tx_code       = i_lp_tx_wake_req ? s_q.tx.tx_wake : s_q.tx.tx_sleep;
  assign o_tx_code_valid = i_lp_tx_wake_req | i_lp_tx_sleep_req;

endmodule // phy_monitor_lowpower_link_cfg

/* hdl/phy_cfg_pkg.sv */
/*
  constants and carriers for the phy monitor / low power / link config block.
  assumes a 25 MHz core clock and a word-wide management register port.
*/
package phy_cfg_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets (management register index)
  localparam logic [15:0] OFF_MON_CTRL   = 16'h046A;
  localparam logic [15:0] OFF_MON_RDBK   = 16'h047B;
  localparam logic [15:0] OFF_SYNC_RSVD  = 16'h0509;
  localparam logic [15:0] OFF_TEARDOWN   = 16'h050A;
  localparam logic [15:0] OFF_LP_CODES   = 16'h0514;
  localparam logic [15:0] OFF_LP_THRESH  = 16'h0515;
  localparam logic [15:0] OFF_MAXWAIT    = 16'h0518;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [15:0] RST_MON_CTRL   = 16'h0094;
  localparam logic [15:0] RST_TEARDOWN   = 16'h1000;
  localparam logic [15:0] RST_LP_CODES   = 16'h08E3;
  localparam logic [15:0] RST_LP_THRESH  = 16'h0808;
  localparam logic [15:0] RST_MAXWAIT    = 16'h17CE;

  // writable masks, reserved bits stay zero
  localparam logic [15:0] MSK_MON_CTRL   = 16'h01FF;
  localparam logic [15:0] MSK_TEARDOWN   = 16'h1800;
  localparam logic [15:0] MSK_LP_CODES   = 16'h0FFF;
  localparam logic [15:0] MSK_LP_THRESH  = 16'h7F7F;
  localparam logic [15:0] MSK_MAXWAIT    = 16'hFFFF;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int MON_START_BIT   = 0;
  localparam int MON_PERIODIC    = 1;
  localparam int MON_RESET_BIT   = 2;
  localparam int MON_FORCE_BIT   = 3;
  localparam int MON_DIV_LSB     = 4;
  localparam int MON_AVG_BIT     = 6;
  localparam int MON_DISC_BIT    = 7;
  localparam int MON_HCLR_BIT    = 8;
  localparam int TD_SEND32_BIT   = 11;
  localparam int TD_FIFO_BIT     = 12;
  localparam int RX_SLEEP_LSB    = 0;
  localparam int RX_WAKE_LSB     = 3;
  localparam int TX_SLEEP_LSB    = 6;
  localparam int TX_WAKE_LSB     = 9;
  localparam int SLEEP_TH_LSB    = 0;
  localparam int WAKE_TH_LSB     = 8;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int  CLK_KHZ         = 25000;
  localparam int  CYC_PER_US      = CLK_KHZ / 1000;
  localparam int  MAXWAIT_SCALE   = 16;
  localparam logic [5:0] SEND_S_COUNT   = 6'h20;    // 32 repeats
  localparam logic [2:0] DISC_FEW       = 3'h2;
  localparam logic [2:0] DISC_MANY      = 3'h4;
  localparam logic [2:0] AVG_FEW        = 3'h2;
  localparam logic [2:0] AVG_MANY       = 3'h4;
  localparam logic [7:0] PERIOD_GAP     = 8'h40;    // gap countdown start; periodic runs sit 65 idle adc ticks apart
  localparam int  HIST_DEPTH     = 16;
  localparam int  HIST_AW        = 4;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [2:0] tx_wake;
    logic [2:0] tx_sleep;
  } lp_tx_t;

endpackage

/* hdl/mon_history_mem.sv */
/*
  small history store for averaged monitor samples, registered read data.
  assumes single clock, one write and one read port.
*/
`timescale 1ns/1ps
module mon_history_mem (
  // clock
  input  wire logic                               i_clk,
  // write side
  input  wire logic                               i_we,
  input  wire logic [phy_cfg_pkg::HIST_AW-1:0]    i_waddr,
  input  wire logic [15:0]                        i_wdata,
  // read side
  input  wire logic [phy_cfg_pkg::HIST_AW-1:0]    i_raddr,
  output logic      [15:0]                        o_rdata
);
  import phy_cfg_pkg::*;

  logic [15:0] mem [HIST_DEPTH];

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end

endmodule // mon_history_mem

/* hdl/lp_code_detect.sv */
/*
  counts consecutive matching code groups and flags when the threshold is met.
  assumes one code group per valid strobe.
*/
`timescale 1ns/1ps
module lp_code_detect (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // code groups
  input  wire logic       i_valid,
  input  wire logic [2:0] i_code,
  input  wire logic [2:0] i_expect,
  input  wire logic [6:0] i_thresh,
  // result
  output logic            o_detect
);
  import phy_cfg_pkg::*;

  typedef struct packed {
    logic [6:0] cnt;
    logic       det;
  } det_state_t;

  det_state_t s_q;
  det_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (i_valid) begin
      if (i_code == i_expect) begin
        if (s_q.cnt != 7'h7F) begin
          s_d.cnt = s_q.cnt + 7'h01;
        end
        if ((s_q.cnt + 7'h01) >= i_thresh) begin
          s_d.det = 1'b1;
        end
      end else begin
        s_d.cnt = 7'h00;
        s_d.det = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_detect = s_q.det;

endmodule // lp_code_detect

/* sim/phy_cfg_monitor.sv */
/*
  concurrent checks for the phy monitor / low power / link config block.
  assumes it is bound to the top module and sees only that module's ports.
*/
`timescale 1ns/1ps
module phy_cfg_monitor (
  // clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  // watched ports
  input  wire phy_cfg_pkg::reg_req_t i_req,
  input  wire logic                  o_rvalid,
  input  wire logic                  o_adc_clk_en,
  input  wire logic                  o_mon_busy,
  input  wire logic                  i_break_timer_run,
  input  wire logic                  i_send_s_slot,
  input  wire logic                  i_training_start,
  input  wire logic                  o_adc_fifo_rst,
  input  wire logic                  o_send_s_tx,
  input  wire logic                  o_maxwait_done,
  input  wire logic                  i_lp_tx_wake_req,
  input  wire logic                  i_lp_tx_sleep_req,
  input  wire logic                  i_rx_cg_valid,
  input  wire logic                  o_tx_code_valid,
  input  wire logic                  o_lp_wake_rcvd,
  input  wire logic                  o_lp_sleep_rcvd
);
  import phy_cfg_pkg::*;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  logic [6:0] slot_q;
  logic       ctl_wr;
  assign ctl_wr = i_req.wr && (i_req.addr == OFF_MON_CTRL);
  // slots sent within the current fixed burst
  always_ff @(posedge i_clk) slot_q <= (i_rst || !o_send_s_tx) ? 7'h00 : slot_q + 7'(i_send_s_slot);

  ////////////////////////////////////////////////////////////
  a_hold_stops_seq: assert property (ctl_wr && i_req.wdata[2] |-> ##2 !o_mon_busy && !o_adc_clk_en)
    else $error("sequencer still active after hold-in-reset write");
  a_start_launches: assert property (ctl_wr && i_req.wdata[3:0] == 4'h9 |-> ##[1:3] o_mon_busy)
    else $error("forced start did not launch the sequencer");
  a_fifo_hold_run: assert property (o_adc_fifo_rst |-> i_break_timer_run)
    else $error("adc fifo reset outside break-link timer");
  a_send_s_count: assert property (o_send_s_tx && i_send_s_slot |-> slot_q < 7'h20)
    else $error("more than 32 fixed send slots");
  a_tx_code_qual: assert property (o_tx_code_valid == (i_lp_tx_wake_req || i_lp_tx_sleep_req))
    else $error("transmit code valid without request");
  a_wake_on_group: assert property ($rose(o_lp_wake_rcvd) |-> $past(i_rx_cg_valid))
    else $error("wake flag rose without a received group");
  a_sleep_on_group: assert property ($rose(o_lp_sleep_rcvd) |-> $past(i_rx_cg_valid))
    else $error("sleep flag rose without a received group");
  a_maxwait_not_early: assert property (i_training_start |=> !o_maxwait_done [*8])
    else $error("max-wait done too soon after load");
  a_read_answer: assert property (i_req.rd |=> o_rvalid ##1 !o_rvalid || $past(i_req.rd, 1))
    else $error("read not answered one cycle later");

  c_mon_run: cover property ($fell(o_mon_busy));
  c_wake_seen: cover property ($rose(o_lp_wake_rcvd));
  c_send_burst: cover property ($fell(o_send_s_tx));
endmodule // phy_cfg_monitor

bind phy_monitor_lowpower_link_cfg phy_cfg_monitor mon_u (.i_clk, .i_rst, .i_req, .o_rvalid, .o_adc_clk_en,
  .o_mon_busy, .i_break_timer_run, .i_send_s_slot, .i_training_start, .o_adc_fifo_rst, .o_send_s_tx,
  .o_maxwait_done, .i_lp_tx_wake_req, .i_lp_tx_sleep_req, .i_rx_cg_valid, .o_tx_code_valid,
  .o_lp_wake_rcvd, .o_lp_sleep_rcvd);

/* sim/link_partner_model.sv */
/*
  remote link partner and monitor adc source for the config block bench.
  assumes a 25 MHz clock; code groups and send slots change on falling edges.
*/
`timescale 1ns/1ps
module link_partner_model (
  // clock and observed state
  input  wire logic        i_clk,
  input  wire logic        i_adc_tick,
  input  wire logic        i_busy,
  // code groups and training
  output logic             o_cg_valid,
  output logic [2:0]       o_cg,
  output logic             o_send_s_seen,
  output logic             o_send_s_slot,
  // adc samples
  output logic             o_adc_valid,
  output logic [15:0]      o_adc_data
);
  logic [15:0] idx;
  initial begin
    o_cg_valid = 1'b0;
    o_cg = 3'h0;
    o_send_s_seen = 1'b0;
    o_send_s_slot = 1'b0;
    idx = 16'h0000;
  end
  // sample k since busy rose carries 4*k; idle bus shows the inverse
  always @(posedge i_clk) idx <= !i_busy ? 16'h0000 : idx + 16'(i_adc_tick);
  assign o_adc_valid = i_busy;
  assign o_adc_data  = i_busy ? (idx << 2) : ~(idx << 2);

  task automatic send_cg(input logic [2:0] c, input int n);
    repeat (n) begin
      @(negedge i_clk);
      o_cg_valid = 1'b1;
      o_cg = c;
    end
    @(negedge i_clk);
    o_cg_valid = 1'b0;
    o_cg = ~c;
  endtask

  task automatic send_s_burst;
    @(negedge i_clk) o_send_s_seen = 1'b1;
    @(negedge i_clk) o_send_s_seen = 1'b0;
    repeat (80) begin
      @(negedge i_clk) o_send_s_slot = 1'b1;
      @(negedge i_clk) o_send_s_slot = 1'b0;
    end
  endtask
endmodule // link_partner_model

/* sim/phy_monitor_lowpower_link_cfg_tb.sv */
/*
  register-level bench for the phy monitor / low power / link config block.
  assumes the link partner model and the bound checker are compiled with it.
*/
`timescale 1ns/1ps
module phy_monitor_lowpower_link_cfg_tb;
  import phy_cfg_pkg::*;
  logic clk = 1'b0, rst = 1'b1, link_up = 1'b0, brk_run = 1'b0, slave = 1'b0, train = 1'b0;
  logic wake_req = 1'b0, sleep_req = 1'b0, rvalid, adc_clk_en, mon_busy, fifo_rst, s_fixed, s_tx, mw_done;
  logic adc_valid, s_seen, s_slot, cg_valid, tx_valid, wake_rcvd, sleep_rcvd;
  logic [2:0] rd_sel = 3'h0, cg, tx_code;
  logic [15:0] rdata, adc_data, v;
  reg_req_t req = '0;
  int error_cnt = 0, num_checks = 0, n, gap, cnt = 0;
  logic [15:0] offs [8] = '{OFF_MON_CTRL, OFF_MON_RDBK, OFF_SYNC_RSVD, OFF_TEARDOWN, OFF_LP_CODES,
                            OFF_LP_THRESH, OFF_MAXWAIT, 16'h0600};
  logic [15:0] rstv [8] = '{16'h0094, 16'h0000, 16'h0000, 16'h1000, 16'h08E3, 16'h0808, 16'h17CE, 16'h0000};
  logic [15:0] msk  [8] = '{16'h00FE, 16'h0000, 16'h0000, 16'h1800, 16'h0FFF, 16'h7F7F, 16'hFFFF, 16'h0000};

  always #20 clk = ~clk;
  always @(posedge clk) if (s_tx && s_slot) cnt <= cnt + 1;

  phy_monitor_lowpower_link_cfg dut_u (.i_clk(clk), .i_rst(rst), .i_req(req), .o_rdata(rdata),
    .o_rvalid(rvalid), .i_link_up(link_up), .i_adc_valid(adc_valid), .i_adc_data(adc_data),
    .i_rd_select(rd_sel), .o_adc_clk_en(adc_clk_en), .o_mon_busy(mon_busy), .i_break_timer_run(brk_run),
    .i_slave_role(slave), .i_send_s_seen(s_seen), .i_send_s_slot(s_slot), .i_training_start(train),
    .o_adc_fifo_rst(fifo_rst), .o_send_s_fixed(s_fixed), .o_send_s_tx(s_tx), .o_maxwait_done(mw_done),
    .i_lp_tx_wake_req(wake_req), .i_lp_tx_sleep_req(sleep_req), .i_rx_cg_valid(cg_valid), .i_rx_cg(cg),
    .o_tx_code(tx_code), .o_tx_code_valid(tx_valid), .o_lp_wake_rcvd(wake_rcvd), .o_lp_sleep_rcvd(sleep_rcvd));

  link_partner_model lp_u (.i_clk(clk), .i_adc_tick(adc_clk_en), .i_busy(mon_busy), .o_cg_valid(cg_valid),
    .o_cg(cg), .o_send_s_seen(s_seen), .o_send_s_slot(s_slot), .o_adc_valid(adc_valid), .o_adc_data(adc_data));

  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk) req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk) req.wr = 1'b0;
  endtask
  task automatic rdc(input logic [15:0] a, input logic [15:0] exp);
    @(negedge clk) req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(negedge clk) req.rd = 1'b0;
    chk(16'(rvalid), 16'h0001);
    chk(rdata, exp);
  endtask
  task automatic busy_wait(input logic want, input int lim);
    n = 0;
    while (mon_busy !== want && n < lim) begin
      @(negedge clk);
      n++;
    end
    chk(16'(mon_busy), 16'(want));
  endtask
  task automatic results;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    #(40 * 30000);
    error_cnt++;
    results();
  end

  ////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 8; i++) rdc(offs[i], rstv[i]);
    for (int i = 0; i < 8; i++) begin
      wr(offs[i], 16'hFFFF);
      rdc(offs[i], msk[i]);
      wr(offs[i], rstv[i]);
    end
    // adc tick spacing per divider code, then gated by hold
    for (int d = 0; d < 3; d++) begin
      wr(OFF_MON_CTRL, 16'(d << 4));
      repeat (2) begin
        n = 0;
        do begin @(negedge clk); n++; end while (!adc_clk_en && n < 20);
        gap = n;
      end
      chk(16'(gap), 16'(2 << d));
    end
    wr(OFF_MON_CTRL, 16'h0004);
    repeat (12) begin @(negedge clk); chk(16'(adc_clk_en), 16'h0000); end
    // single runs: discard then average the ramp 4*k
    for (int i = 0; i < 3; i++) begin
      v = (16'(i == 1) << 7) | (16'(i != 0) << 6) | 16'h0009;
      wr(OFF_MON_CTRL, v);
      busy_wait(1'b1, 4);
      rdc(OFF_MON_CTRL, v & 16'hFFFE);
      busy_wait(1'b0, 300);
      for (int s = 0; s < 2; s++) begin
        rd_sel = 3'(s);
        rdc(OFF_MON_RDBK, 16'(4 * ((i == 1) ? 4 : 2) + 2 * ((i != 0) ? 3 : 1)));
      end
    end
    rd_sel = 3'h0;
    wr(OFF_MON_CTRL, 16'h0100);
    rdc(OFF_MON_CTRL, 16'h0000);
    rdc(OFF_MON_RDBK, 16'h0000);
    // start without link waits until link comes up
    wr(OFF_MON_CTRL, 16'h0001);
    repeat (20) @(negedge clk);
    chk(16'(mon_busy), 16'h0000);
    link_up = 1'b1;
    busy_wait(1'b1, 10);
    busy_wait(1'b0, 300);
    link_up = 1'b0;
    // periodic runs restart by themselves, hold stops them at once
    wr(OFF_MON_CTRL, 16'h000B);
    busy_wait(1'b1, 4);
    // second run starts after 65 gap ticks: ramp index 69, average 286
    repeat (200) @(negedge clk);
    rdc(OFF_MON_RDBK, 16'h011E);
    busy_wait(1'b1, 0);
    wr(OFF_MON_CTRL, 16'h0004);
    @(negedge clk);
    chk(16'(mon_busy), 16'h0000);
    // fifo hold during break-link timer
    brk_run = 1'b1;
    @(negedge clk) chk(16'(fifo_rst), 16'h0001);
    wr(OFF_TEARDOWN, 16'h0000);
    chk(16'(fifo_rst), 16'h0000);
    brk_run = 1'b0;
    // fixed send burst, sync link bit 10 reads zero so enabling is allowed
    wr(OFF_TEARDOWN, 16'h0800);
    chk(16'(s_fixed), 16'h0001);
    slave = 1'b1;
    lp_u.send_s_burst();
    chk(16'(cnt), 16'd32);
    chk(16'(s_tx), 16'h0000);
    slave = 1'b0;
    // low power codes and thresholds
    wr(OFF_LP_CODES, 16'h0AB1);
    wr(OFF_LP_THRESH, 16'h0302);
    wake_req = 1'b1;
    sleep_req = 1'b1;
    @(negedge clk) chk({12'h000, tx_valid, tx_code}, 16'h000D);
    wake_req = 1'b0;
    @(negedge clk) chk({12'h000, tx_valid, tx_code}, 16'h000A);
    sleep_req = 1'b0;
    lp_u.send_cg(3'h4, 4);
    chk(16'(wake_rcvd), 16'h0000);
    lp_u.send_cg(3'h6, 2);
    chk(16'(wake_rcvd), 16'h0000);
    lp_u.send_cg(3'h6, 3);
    chk(16'(wake_rcvd), 16'h0001);
    lp_u.send_cg(3'h1, 1);
    chk({wake_rcvd, sleep_rcvd}, 16'h0000);
    lp_u.send_cg(3'h1, 2);
    chk(16'(sleep_rcvd), 16'h0001);
    // max-wait of one 16 us unit
    wr(OFF_MAXWAIT, 16'h0001);
    @(negedge clk) train = 1'b1;
    @(negedge clk) train = 1'b0;
    repeat (MAXWAIT_SCALE * CYC_PER_US - 15) @(negedge clk);
    chk(16'(mw_done), 16'h0000);
    n = 0;
    while (!mw_done && n < 40) begin @(negedge clk); n++; end
    chk(16'(mw_done), 16'h0001);
    results();
  end
endmodule // phy_monitor_lowpower_link_cfg_tb
